// ==== core/transient_recorder_acq_control.sv ====
// acquisition control of the transient recorder, wishbone register slave
// Overview of operation
// - hold recording length per active channel
// - record exactly post count after trigger
// - pre-trigger equals length minus post count
// - post counter capped by channel count
// - length and post are granule multiples
// - code 10 latches setup, starts recording
// - wait settling interval before counting samples
// - code 20 aborts at once, any state
// - run alone, stop after post samples
// - status readable anytime without side effects
// - status 0 waiting, 10 triggered, 20 stopped
// - code 11 starts, interrupts at end
// - no trigger or clock: never completes
// - ring buffer writes while awaiting trigger
// - trigger disarmed until pre-trigger filled
`timescale 1ns/100ps
module transient_recorder_acq_control
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // acquisition front end, same clock
    input  wire logic        sample_valid_i,
    input  wire logic        trigger_i,
    // memory write side
    output logic             mem_we_o,
    output logic      [31:0] mem_addr_o,
    output logic             mem_arm_o,
    // end of acquisition interrupt
    output logic             end_irq_o
);
    import acq_ctrl_pkg::*;

    acq_state_t  state_r;
    logic [31:0] rec_length_r;
    logic [31:0] after_trig_r;
    logic [31:0] wait_limit_r;
    logic [31:0] settle_r;
    logic [1:0]  chan_sel_r;
    logic [31:0] run_length_r;
    logic [31:0] run_after_r;
    logic [31:0] run_pre_r;
    logic        run_irq_en_r;
    logic [31:0] count_r;
    logic [31:0] wr_addr_r;
    logic [31:0] status_r;

    function automatic logic [31:0] gran_mask(input logic [1:0] sel);
        case (sel)
            CH_ONE:  gran_mask = GRAN_MASK_ONE;
            CH_TWO:  gran_mask = GRAN_MASK_TWO;
            default: gran_mask = GRAN_MASK_FOUR;
        endcase
    endfunction

    function automatic logic [31:0] post_max(input logic [1:0] sel);
        case (sel)
            CH_ONE:  post_max = POST_MAX_ONE;
            CH_TWO:  post_max = POST_MAX_TWO;
            default: post_max = POST_MAX_FOUR;
        endcase
    endfunction

    function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        byte_merge = res;
    endfunction

    logic bus_req;
    logic wr_req;
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_req  = bus_req && wb_we_i;

    logic cmd_write;
    logic cmd_start;
    logic cmd_start_irq;
    logic cmd_abort;
    assign cmd_write     = wr_req && (wb_adr_i == ADDR_COMMAND);
    assign cmd_start     = cmd_write && (wb_dat_i == BEGIN_ACQUISITION_CODE);
    assign cmd_start_irq = cmd_write && (wb_dat_i == BEGIN_WITH_END_INTERRUPT_CODE);
    assign cmd_abort     = cmd_write && (wb_dat_i == ABORT_ACQUISITION_CODE);

    logic [31:0] len_wr;
    logic [31:0] post_wr;
    logic [31:0] post_cap;
    assign len_wr   = byte_merge(rec_length_r, wb_dat_i, wb_sel_i) & gran_mask(chan_sel_r);
    assign post_cap = byte_merge(after_trig_r, wb_dat_i, wb_sel_i) & gran_mask(chan_sel_r);
    assign post_wr  = (post_cap > post_max(chan_sel_r)) ? post_max(chan_sel_r) : post_cap;

    // single cycle ack, one wait-free answer per request
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req;
    end

    // pending setup; length and post take effect only when latched at start, settle_r is used live
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rec_length_r <= REC_LENGTH_RST;
            after_trig_r <= AFTER_TRIG_RST;
            wait_limit_r <= WAIT_LIMIT_RST;
            settle_r     <= SETTLE_RST;
            chan_sel_r   <= CH_ONE;
        end
        else if (wr_req)
        begin
            if (wb_adr_i == ADDR_REC_LENGTH)
                rec_length_r <= len_wr;
            if (wb_adr_i == ADDR_AFTER_TRIG)
                after_trig_r <= post_wr;
            if (wb_adr_i == ADDR_WAIT_LIMIT)
                wait_limit_r <= byte_merge(wait_limit_r, wb_dat_i, wb_sel_i);
            if (wb_adr_i == ADDR_SETTLE)
                settle_r <= byte_merge(settle_r, wb_dat_i, wb_sel_i);
            if ((wb_adr_i == ADDR_CHAN_COUNT) && wb_sel_i[0] && (wb_dat_i[1:0] != 2'h3))
                chan_sel_r <= wb_dat_i[1:0];
        end
    end

    // run copy of setup, latched at start only
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            run_length_r <= REC_LENGTH_RST;
            run_after_r  <= AFTER_TRIG_RST;
            run_pre_r    <= ZERO_WORD;
            run_irq_en_r <= 1'b0;
        end
        else if ((cmd_start || cmd_start_irq) && state_r == ST_STOPPED)
        begin
            run_length_r <= rec_length_r;
            run_after_r  <= after_trig_r;
            // clamp guards a host that breaks the length bound
            run_pre_r    <= (after_trig_r > rec_length_r) ? ZERO_WORD
                                                          : rec_length_r - after_trig_r;
            run_irq_en_r <= cmd_start_irq;
        end
    end

    // acquisition sequencer
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_r <= ST_STOPPED;
            count_r <= ZERO_WORD;
        end
        else if (cmd_abort)
        begin
            state_r <= ST_STOPPED;
            count_r <= ZERO_WORD;
        end
        else
        begin
            case (state_r)
                ST_STOPPED:
                begin
                    if (cmd_start || cmd_start_irq)
                    begin
                        state_r <= ST_SETTLE;
                        count_r <= ZERO_WORD;
                    end
                end
                ST_SETTLE:
                begin
                    if (count_r >= settle_r)
                    begin
                        state_r <= ST_PREFILL;
                        count_r <= ZERO_WORD;
                    end
                    else
                        count_r <= count_r + ONE_WORD;
                end
                ST_PREFILL:
                begin
                    if (count_r >= run_pre_r)
                        state_r <= ST_ARMED;
                    else if (sample_valid_i)
                        count_r <= count_r + ONE_WORD;
                end
                ST_ARMED:
                begin
                    // no trigger means this state holds until abort
                    if (trigger_i && sample_valid_i)
                    begin
                        state_r <= ST_POST;
                        count_r <= ONE_WORD;
                        if (run_after_r == ONE_WORD)
                            state_r <= ST_STOPPED;
                    end
                end
                ST_POST:
                begin
                    if (sample_valid_i)
                    begin
                        if (count_r + ONE_WORD >= run_after_r)
                            state_r <= ST_STOPPED;
                        count_r <= count_r + ONE_WORD;
                    end
                end
                default:
                begin
                    state_r <= ST_STOPPED;
                    count_r <= ZERO_WORD;
                end
            endcase
        end
    end

    logic counting;
    assign counting = sample_valid_i && !cmd_abort &&
                      (state_r == ST_PREFILL || state_r == ST_ARMED || state_r == ST_POST);

    // ring buffer address within the programmed region
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wr_addr_r  <= ZERO_WORD;
            mem_we_o   <= 1'b0;
            mem_addr_o <= ZERO_WORD;
            mem_arm_o  <= 1'b0;
        end
        else
        begin
            mem_we_o   <= counting;
            mem_addr_o <= wr_addr_r;
            mem_arm_o  <= (state_r == ST_ARMED) && !cmd_abort;
            if (state_r == ST_STOPPED)
                wr_addr_r <= ZERO_WORD;
            else if (counting)
                wr_addr_r <= (wr_addr_r + ONE_WORD >= run_length_r) ? ZERO_WORD
                                                                    : wr_addr_r + ONE_WORD;
        end
    end

    // status code
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            status_r <= STOPPED_STATE;
        else
        begin
            case (state_r)
                ST_STOPPED: status_r <= STOPPED_STATE;
                ST_POST:    status_r <= TRIGGERED_RECORDING_STATE;
                default:    status_r <= ARMED_WAITING_STATE;
            endcase
        end
    end

    // end interrupt, sticky until cleared; a new end wins over the clear
    logic done_evt;
    assign done_evt = run_irq_en_r && !cmd_abort && sample_valid_i &&
                      ((state_r == ST_POST && count_r + ONE_WORD >= run_after_r) ||
                       (state_r == ST_ARMED && trigger_i && run_after_r == ONE_WORD));
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            end_irq_o <= 1'b0;
        else if (done_evt)
            end_irq_o <= 1'b1;
        else if (wr_req && wb_adr_i == ADDR_CONTROL && wb_sel_i[0] && wb_dat_i[CTRL_IRQ_BIT])
            end_irq_o <= 1'b0;
        else if (cmd_start || cmd_start_irq)
            end_irq_o <= 1'b0;
    end

    // read mux; reads have no side effects
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            wb_dat_o <= ZERO_WORD;
        else if (bus_req && !wb_we_i)
        begin
            case (wb_adr_i)
                ADDR_COMMAND:    wb_dat_o <= ZERO_WORD;
                ADDR_RUN_STATE:  wb_dat_o <= status_r;
                ADDR_REC_LENGTH: wb_dat_o <= rec_length_r;
                ADDR_AFTER_TRIG: wb_dat_o <= after_trig_r;
                ADDR_WAIT_LIMIT: wb_dat_o <= wait_limit_r;
                ADDR_SETTLE:     wb_dat_o <= settle_r;
                ADDR_CHAN_COUNT: wb_dat_o <= {30'h0, chan_sel_r};
                ADDR_CONTROL:    wb_dat_o <= {31'h0, end_irq_o};
                default:         wb_dat_o <= ZERO_WORD;
            endcase
        end
    end
endmodule

// ==== shared/acq_ctrl_pkg.sv ====
// constants for the transient recorder acquisition control
package acq_ctrl_pkg;
    // register indices, byte address is four times the index
    localparam int unsigned IDX_COMMAND    = 32'h0000_0000;
    localparam int unsigned IDX_RUN_STATE  = 32'h0000_000a;
    localparam int unsigned IDX_REC_LENGTH = 32'h0000_2710;
    localparam int unsigned IDX_AFTER_TRIG = 32'h0000_2774;
    localparam int unsigned IDX_WAIT_LIMIT = 32'h0004_80da;
    localparam int unsigned IDX_CHAN_COUNT = 32'h0000_2800;
    localparam int unsigned IDX_SETTLE     = 32'h0000_2801;
    localparam int unsigned IDX_CONTROL    = 32'h0000_2802;

    localparam logic [31:0] ADDR_COMMAND    = 32'(IDX_COMMAND * 4);
    localparam logic [31:0] ADDR_RUN_STATE  = 32'(IDX_RUN_STATE * 4);
    localparam logic [31:0] ADDR_REC_LENGTH = 32'(IDX_REC_LENGTH * 4);
    localparam logic [31:0] ADDR_AFTER_TRIG = 32'(IDX_AFTER_TRIG * 4);
    localparam logic [31:0] ADDR_WAIT_LIMIT = 32'(IDX_WAIT_LIMIT * 4);
    localparam logic [31:0] ADDR_CHAN_COUNT = 32'(IDX_CHAN_COUNT * 4);
    localparam logic [31:0] ADDR_SETTLE     = 32'(IDX_SETTLE * 4);
    localparam logic [31:0] ADDR_CONTROL    = 32'(IDX_CONTROL * 4);

    // command codes
    localparam logic [31:0] BEGIN_ACQUISITION_CODE          = 32'h0000_000a;
    localparam logic [31:0] BEGIN_WITH_END_INTERRUPT_CODE   = 32'h0000_000b;
    localparam logic [31:0] ABORT_ACQUISITION_CODE          = 32'h0000_0014;

    // status codes
    localparam logic [31:0] ARMED_WAITING_STATE       = 32'h0000_0000;
    localparam logic [31:0] TRIGGERED_RECORDING_STATE = 32'h0000_000a;
    localparam logic [31:0] STOPPED_STATE             = 32'h0000_0014;

    // channel count selector codes (0: one, 1: two, 2: four)
    localparam logic [1:0] CH_ONE  = 2'h0;
    localparam logic [1:0] CH_TWO  = 2'h1;
    localparam logic [1:0] CH_FOUR = 2'h2;

    // post trigger counter ceiling in samples per channel
    localparam logic [31:0] POST_MAX_ONE  = 32'h0800_0000;
    localparam logic [31:0] POST_MAX_TWO  = 32'h0400_0000;
    localparam logic [31:0] POST_MAX_FOUR = 32'h0200_0000;

    // granule masks: low bits cleared on write
    localparam logic [31:0] GRAN_MASK_ONE  = 32'hffff_ffe0;
    localparam logic [31:0] GRAN_MASK_TWO  = 32'hffff_fff0;
    localparam logic [31:0] GRAN_MASK_FOUR = 32'hffff_fff8;

    // reset values
    localparam logic [31:0] REC_LENGTH_RST = 32'h0000_0400;
    localparam logic [31:0] AFTER_TRIG_RST = 32'h0000_0200;
    localparam logic [31:0] WAIT_LIMIT_RST = 32'h0000_0000;
    localparam logic [31:0] SETTLE_RST     = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
    localparam logic [31:0] ONE_WORD       = 32'h0000_0001;

    // control register bit: end interrupt pending, write one to clear
    localparam int unsigned CTRL_IRQ_BIT = 0;

    typedef enum logic [2:0] {
        ST_STOPPED = 3'b000,
        ST_SETTLE  = 3'b001,
        ST_PREFILL = 3'b010,
        ST_ARMED   = 3'b011,
        ST_POST    = 3'b100
    } acq_state_t;
endpackage

// ==== testbench/acq_control_asserts.sv ====
// concurrent checks on the acquisition control ports
`timescale 1ns/100ps
module acq_control_asserts
(
    // clock and reset
    input wire logic        clock_i,
    input wire logic        reset_i,
    // bus and front end
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        sample_valid_i,
    // watched outputs
    input wire logic        mem_we_o,
    input wire logic        mem_arm_o,
    input wire logic        end_irq_o
);
    import acq_ctrl_pkg::*;
    logic req;
    logic cmd_wr;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cmd_wr = req && wb_we_i && wb_adr_i == ADDR_COMMAND;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_ack_next; req |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_cmd_zero;
        wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == ADDR_COMMAND |-> wb_dat_o == ZERO_WORD;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("command read not 0");
    property p_we_cause; mem_we_o |-> $past(sample_valid_i); endproperty
    a_we_cause: assert property (p_we_cause) else $error("write without sample");
    property p_abort;
        cmd_wr && wb_dat_i == ABORT_ACQUISITION_CODE |=> (!mem_we_o && !mem_arm_o) [*3];
    endproperty
    a_abort: assert property (p_abort) else $error("abort not at once");
    property p_irq_sticky; end_irq_o && !(wb_cyc_i && wb_stb_i) |=> end_irq_o; endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped");
    property p_irq_cause;
        $rose(end_irq_o) |-> $past(sample_valid_i) || $past(sample_valid_i, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without sample");
endmodule

bind transient_recorder_acq_control acq_control_asserts u_chk
(
    .clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sample_valid_i(sample_valid_i), .mem_we_o(mem_we_o),
    .mem_arm_o(mem_arm_o), .end_irq_o(end_irq_o)
);

// ==== testbench/host_model.sv ====
// host side model issuing classic wishbone register cycles
`timescale 1ns/100ps
module host_model
(
    // clock
    input  wire logic        clock_i,
    // wishbone master
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic      [31:0] adr_o,
    output logic      [3:0]  sel_o,
    output logic      [31:0] dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    initial
    begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 32'h0;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end
    // released address and data lines show the inverse, never the stale value
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hf;
        dat_o <= d;
        do
        begin
            @(posedge clock_i);
            n++;
        end
        while (ack_i !== 1'b1 && n < 20);
        q = dat_i;
        if (ack_i !== 1'b1)
        begin
            tb.chk("ack", 32'h1, 32'h0);
            tb.finish_test();
        end
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        adr_o <= ~a;
        dat_o <= ~d;
    endtask
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the acquisition control block
`timescale 1ns/100ps
module tb;
    import acq_ctrl_pkg::*;
    logic        clock_i;
    logic        reset_i;
    logic        cyc, stb, we, ack, sv, trigger_i, mwe, arm, irq, feed;
    logic [31:0] adr, dw, dr, maddr;
    logic [3:0]  sel;
    logic [31:0] exp_addr;
    logic [31:0] exp_len;
    int          we_cnt;
    int          n_errors;
    int          cmp_count;
    transient_recorder_acq_control u_dut
    (
        .clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .sample_valid_i(sv), .trigger_i(trigger_i), .mem_we_o(mwe),
        .mem_addr_o(maddr), .mem_arm_o(arm), .end_irq_o(irq)
    );
    host_model u_host
    (
        .clock_i(clock_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(dw), .dat_i(dr), .ack_i(ack)
    );
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        u_host.xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    task automatic chk_irq(input logic e);
        @(negedge clock_i);
        chk("end irq", 32'(e), 32'(irq));
    endtask
    // k selects the end interrupt, else the arm flag
    task automatic wait_for(input string nm, input bit k);
        int n;
        n = 0;
        while ((k ? irq : arm) !== 1'b1 && n < 600)
        begin
            @(negedge clock_i);
            n++;
        end
        if ((k ? irq : arm) !== 1'b1)
        begin
            chk(nm, 32'h1, 32'h0);
            finish_test();
        end
    endtask
    task automatic t_reset();
        rc("status", ADDR_RUN_STATE, STOPPED_STATE);
        rc("length", ADDR_REC_LENGTH, REC_LENGTH_RST);
        rc("post", ADDR_AFTER_TRIG, AFTER_TRIG_RST);
        rc("command", ADDR_COMMAND, ZERO_WORD);
        rc("unmapped", 32'h0000_0ff0, ZERO_WORD);
        wr(ADDR_WAIT_LIMIT, 32'h0000_03e8);
        rc("limit", ADDR_WAIT_LIMIT, 32'h0000_03e8);
        $display("reset test done");
    endtask
    task automatic t_gran();
        logic [31:0] m [3] = '{GRAN_MASK_ONE, GRAN_MASK_TWO, GRAN_MASK_FOUR};
        logic [31:0] t [3] = '{POST_MAX_ONE, POST_MAX_TWO, POST_MAX_FOUR};
        for (int c = 0; c < 3; c++)
        begin
            wr(ADDR_CHAN_COUNT, 32'(c));
            wr(ADDR_REC_LENGTH, 32'h0000_041f);
            rc("step", ADDR_REC_LENGTH, 32'h0000_041f & m[c]);
            wr(ADDR_AFTER_TRIG, 32'hffff_ffff);
            rc("ceiling", ADDR_AFTER_TRIG, t[c]);
        end
        wr(ADDR_CHAN_COUNT, 32'h0000_0003);
        rc("chan count", ADDR_CHAN_COUNT, 32'(CH_FOUR));
        $display("granule test done");
    endtask
    task automatic t_run();
        wr(ADDR_CHAN_COUNT, 32'(CH_ONE));
        wr(ADDR_REC_LENGTH, 32'h0000_0040);
        wr(ADDR_AFTER_TRIG, 32'h0000_0020);
        wr(ADDR_SETTLE, 32'h0000_0003);
        feed <= 1'b1;
        we_cnt = 0;
        exp_addr = 32'h0;
        exp_len = 32'h0000_0040;
        wr(ADDR_COMMAND, BEGIN_WITH_END_INTERRUPT_CODE);
        rc("waiting", ADDR_RUN_STATE, ARMED_WAITING_STATE);
        wait_for("arm", 1'b0);
        chk("prefill", 32'h20, 32'(we_cnt));
        @(posedge clock_i);
        feed <= 1'b0;
        repeat (4) @(posedge clock_i);
        we_cnt = 0;
        trigger_i <= 1'b1;
        feed <= 1'b1;
        repeat (6) @(posedge clock_i);
        trigger_i <= 1'b0;
        rc("triggered", ADDR_RUN_STATE, TRIGGERED_RECORDING_STATE);
        wr(ADDR_REC_LENGTH, 32'h0000_0080);
        wait_for("end", 1'b1);
        repeat (2) @(negedge clock_i);
        chk("post count", 32'h20, 32'(we_cnt));
        @(posedge clock_i);
        feed <= 1'b0;
        rc("stopped", ADDR_RUN_STATE, STOPPED_STATE);
        rc("new length", ADDR_REC_LENGTH, 32'h0000_0080);
        chk_irq(1'b1);
        wr(ADDR_CONTROL, ONE_WORD);
        chk_irq(1'b0);
        $display("run test done");
    endtask
    task automatic t_abort();
        wr(ADDR_COMMAND, 32'h0000_0005);
        rc("bad cmd", ADDR_RUN_STATE, STOPPED_STATE);
        feed <= 1'b1;
        exp_addr = 32'h0;
        exp_len = 32'h0000_0080;
        wr(ADDR_COMMAND, BEGIN_ACQUISITION_CODE);
        wait_for("arm", 1'b0);
        wr(ADDR_COMMAND, ABORT_ACQUISITION_CODE);
        rc("aborted", ADDR_RUN_STATE, STOPPED_STATE);
        we_cnt = 0;
        repeat (20) @(posedge clock_i);
        feed <= 1'b0;
        chk("idle writes", 32'h0, 32'(we_cnt));
        chk_irq(1'b0);
        $display("abort test done");
    endtask
    initial
    begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    always @(posedge clock_i)
        sv <= feed && !sv;
    // ring address must wrap at the length latched at start, not a later write
    always @(posedge clock_i)
        if (mwe === 1'b1)
        begin
            we_cnt++;
            chk("ring address", exp_addr, maddr);
            exp_addr = (exp_addr + 32'h1 >= exp_len) ? 32'h0 : exp_addr + 32'h1;
        end
    initial
    begin
        reset_i = 1'b1;
        trigger_i = 1'b0;
        feed = 1'b0;
        exp_addr = 32'h0;
        exp_len = 32'h0000_0040;
        we_cnt = 0;
        n_errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        t_reset();
        t_gran();
        t_run();
        t_abort();
        finish_test();
    end
endmodule
